/* verilog/dps_pkg.sv */
// Shared constants, types and helpers of the dual pulse and density generator.
// Assumes one 125 MHz system clock and an APB master with 32-bit data.
package dps_pkg;

  localparam int ADDR_W = 8;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] DPS_OFF_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] DPS_OFF_DUTY_LO = 8'h04;
  localparam logic [ADDR_W-1:0] DPS_OFF_DUTY_HI = 8'h08;
  localparam logic [ADDR_W-1:0] DPS_OFF_PER_LO  = 8'h0c;
  localparam logic [ADDR_W-1:0] DPS_OFF_PER_HI  = 8'h10;
  localparam logic [ADDR_W-1:0] DPS_OFF_STATUS  = 8'h14;

  // Prescaler divide ratios.
  localparam logic [6:0] DPS_DIV1  = 7'h01;
  localparam logic [6:0] DPS_DIV4  = 7'h04;
  localparam logic [6:0] DPS_DIV16 = 7'h10;
  localparam logic [6:0] DPS_DIV64 = 7'h40;

  localparam logic [1:0]  DPS_SRC_SYSCLK = 2'h3;
  localparam logic [15:0] DPS_CNT_TOP    = 16'hffff;

  typedef enum logic [2:0] {
    DPS_MODE_OFF      = 3'h0,
    DPS_MODE_SINGLE16 = 3'h1,
    DPS_MODE_TWIN8    = 3'h2,
    DPS_MODE_TWIN16   = 3'h3,
    DPS_MODE_NRZ      = 3'h4,
    DPS_MODE_DUAL8    = 3'h5,
    DPS_MODE_RZ       = 3'h6,
    DPS_MODE_HOLD     = 3'h7
  } dps_mode_t;

  // Control word layout: mode in [6:4], prescaler in [3:2], source in [1:0].
  typedef struct packed {
    dps_mode_t  mode;
    logic [1:0] prescale_sel;
    logic [1:0] clock_source_sel;
  } dps_ctrl_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } dps_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } dps_apb_rsp_t;

  typedef struct packed {
    dps_ctrl_t   ctrl;
    logic [15:0] duty_val;
    logic [15:0] period_val;
    logic [15:0] pend_duty;
    logic [15:0] pend_period;
    logic [7:0]  hold_duty;
    logic [7:0]  hold_period;
    logic        pend_duty_vld;
    logic        pend_period_vld;
    logic [15:0] cnt;
    logic [15:0] acc0;
    logic [15:0] acc1;
    logic [5:0]  pre;
    logic [2:0]  src_meta;
    logic [2:0]  src_sync;
    logic [2:0]  src_prev;
    logic        out0;
    logic        out1;
    logic        oe0;
    logic        oe1;
    logic        ready;
    logic        slverr;
    logic [31:0] rdata;
  } dps_state_t;

  localparam dps_state_t DPS_STATE_RST = '0;

  function automatic logic [6:0] dps_div(input logic [1:0] sel);
    case (sel)
      2'h0:    dps_div = DPS_DIV1;
      2'h1:    dps_div = DPS_DIV4;
      2'h2:    dps_div = DPS_DIV16;
      default: dps_div = DPS_DIV64;
    endcase
  endfunction

  // Modes whose values are sixteen bits wide and go through the holding stage.
  function automatic logic dps_is_wide(input dps_mode_t m);
    dps_is_wide = (m == DPS_MODE_SINGLE16) || (m == DPS_MODE_TWIN16) ||
                  (m == DPS_MODE_NRZ) || (m == DPS_MODE_RZ);
  endfunction

endpackage

/* verilog/dps_pulse_gen.sv */
// Dual pulse-width and pulse-density generator with an APB register slave.
// Assumes clk at 125 MHz, an APB master on the same clock, and three
// asynchronous clock source pins that are synchronised here.
//
// Notes on behaviour
// - Twin 8-bit: first output falls when counter equals duty low byte.
// - Twin 8-bit: second output rises at period high byte, falls at duty high.
// - Twin 8-bit: period high byte zero starts both pulses together.
// - Twin 16-bit: counter runs the full 65536 range, ignoring period.
// - Twin 16-bit: first output high while counter below duty value.
// - Twin 16-bit: second output high while counter below period value.
// - Twin 16-bit: both outputs go high together after the wrap to zero.
// - Non-return density: first output high duty clocks per 65536 clocks.
// - Non-return density: second output high period clocks per 65536.
// - Density high clocks are spread evenly by an accumulator carry.
// - Dual 8-bit: each output has its own duty and period.
// - Return density: each high clock is half high, then half low, except at divide-by-1.
// - Return density with 4010H: three low clocks, half high, half low.
// - Dual 8-bit: period bytes set resolution, duty bytes set duty.
// - Both outputs share one clock source and one prescaler.
// - Mode 7 stops pulses and releases both pins.
// - Control write resets counter; prescaler divides by 1, 4, 16, 64.
// - Wide modes: low byte held; high byte commits both at next counter cycle, or at next tick in density modes.
// - Twin 8-bit: period low byte sets the common period.
module dps_pulse_gen
  import dps_pkg::*;
(
  // Clock and reset.
  input  wire logic               clk,
  input  wire logic               rst_b,
  // Register bus.
  input  wire dps_pkg::dps_apb_req_t apb_req,
  output dps_pkg::dps_apb_rsp_t   apb_rsp,
  // Clock source pins: slow crystal, crystal, external input.
  input  wire logic [2:0]         clock_src_pins,
  // Pulse pins.
  output logic                    first_pulse_out,
  output logic                    first_pulse_oe,
  output logic                    second_pulse_out,
  output logic                    second_pulse_oe
);
  import dps_pkg::*;

  logic [1:0]  rst_sync_q;
  logic        rst_n;
  dps_state_t  s_q;
  dps_state_t  s_d;
  logic [6:0]  div;
  logic [3:0]  src_edges;
  logic        ev;
  logic        run;
  logic        tick;
  logic        wrap;
  logic        commit;
  logic        density;
  logic        bus_start;
  logic        bus_done;
  logic        ctrl_wr;
  logic [16:0] sum0;
  logic [16:0] sum1;
  logic [7:0]  lo;
  logic [7:0]  hi;
  logic        below0_8;
  logic        below1_8;

  // Reset is released through two flip-flops; the rest uses that copy.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  assign lo = s_q.cnt[7:0];
  assign hi = s_q.cnt[15:8];
  assign below0_8 = lo < s_q.duty_val[7:0];
  assign below1_8 = hi < s_q.duty_val[15:8];
  assign sum0 = {1'b0, s_q.acc0} + {1'b0, s_q.duty_val};
  assign sum1 = {1'b0, s_q.acc1} + {1'b0, s_q.period_val};
  assign bus_start = apb_req.psel & apb_req.penable & ~s_q.ready;
  assign bus_done = apb_req.psel & apb_req.penable & s_q.ready;
  assign ctrl_wr = bus_done & apb_req.pwrite & (apb_req.paddr == DPS_OFF_CTRL);

  always_comb begin
    s_d = s_q;
    // Only the second and third stages are read by the edge logic.
    s_d.src_meta = clock_src_pins;
    s_d.src_sync = s_q.src_meta;
    s_d.src_prev = s_q.src_sync;

    // One source and one prescaler serve both outputs.
    div = dps_div(s_q.ctrl.prescale_sel);
    src_edges = {1'b1, s_q.src_sync & ~s_q.src_prev};
    ev = src_edges[s_q.ctrl.clock_source_sel];
    run = (s_q.ctrl.mode != DPS_MODE_OFF) && (s_q.ctrl.mode != DPS_MODE_HOLD);
    tick = run & ev & ({1'b0, s_q.pre} == div - 7'h01);
    density = (s_q.ctrl.mode == DPS_MODE_NRZ) || (s_q.ctrl.mode == DPS_MODE_RZ);
    if (run & ev) begin
      s_d.pre = tick ? 6'h00 : s_q.pre + 6'h01;
    end

    case (s_q.ctrl.mode)
      DPS_MODE_SINGLE16: wrap = s_q.cnt == s_q.period_val - 16'h0001;
      DPS_MODE_TWIN8:    wrap = lo == s_q.period_val[7:0];
      default:           wrap = s_q.cnt == DPS_CNT_TOP;
    endcase

    // Mode decode; each branch is one counter cycle step.
    if (tick) begin
      case (s_q.ctrl.mode)
        DPS_MODE_SINGLE16: begin
          s_d.cnt = wrap ? 16'h0000 : s_q.cnt + 16'h0001;
          s_d.out0 = s_q.cnt < s_q.duty_val;
          s_d.out1 = 1'b0;
        end
        DPS_MODE_TWIN8: begin
          s_d.cnt = {8'h00, wrap ? 8'h00 : lo + 8'h01};
          if (lo == s_q.duty_val[7:0]) begin
            s_d.out0 = 1'b0;
          end else if (lo == 8'h00) begin
            s_d.out0 = 1'b1;
          end
          if (lo == s_q.duty_val[15:8]) begin
            s_d.out1 = 1'b0;
          end else if (lo == s_q.period_val[15:8]) begin
            s_d.out1 = 1'b1;
          end
        end
        DPS_MODE_TWIN16: begin
          s_d.cnt = s_q.cnt + 16'h0001;
          s_d.out0 = s_q.cnt < s_q.duty_val;
          s_d.out1 = s_q.cnt < s_q.period_val;
        end
        DPS_MODE_NRZ, DPS_MODE_RZ: begin
          // The carry of a 16-bit accumulator gives exactly value highs in 65536.
          s_d.cnt = s_q.cnt + 16'h0001;
          s_d.acc0 = sum0[15:0];
          s_d.acc1 = sum1[15:0];
          s_d.out0 = sum0[16];
          s_d.out1 = sum1[16];
        end
        DPS_MODE_DUAL8: begin
          s_d.cnt[7:0] = (lo == s_q.period_val[7:0]) ? 8'h00 : lo + 8'h01;
          s_d.cnt[15:8] = (hi == s_q.period_val[15:8]) ? 8'h00 : hi + 8'h01;
          s_d.out0 = below0_8;
          s_d.out1 = below1_8;
        end
        default: begin
          s_d.cnt = 16'h0000;
        end
      endcase
    end

    // Return to zero: a high tick lasts only the first half of the prescaled
    // period, so the output falls on the source edge that ends that half.
    // Divide-by-1 has no half, so a high tick is never split and back-to-back
    // highs merge; divide-by-4 is the intended setting.
    if ((s_q.ctrl.mode == DPS_MODE_RZ) && ev && !tick &&
        ({1'b0, s_q.pre} + 7'h01 >= (div >> 1))) begin
      s_d.out0 = 1'b0;
      s_d.out1 = 1'b0;
    end

    if (!run) begin
      s_d.cnt = 16'h0000;
      s_d.pre = 6'h00;
      s_d.acc0 = 16'h0000;
      s_d.acc1 = 16'h0000;
      s_d.out0 = 1'b0;
      s_d.out1 = 1'b0;
    end
    s_d.oe0 = run;
    s_d.oe1 = run && (s_q.ctrl.mode != DPS_MODE_SINGLE16);

    // Committed wide values wait for the end of the running counter cycle; density modes take them on the next tick.
    commit = (tick & (wrap | density)) | ~run;
    if (commit && s_q.pend_duty_vld) begin
      s_d.duty_val = s_q.pend_duty;
      s_d.pend_duty_vld = 1'b0;
    end
    if (commit && s_q.pend_period_vld) begin
      s_d.period_val = s_q.pend_period;
      s_d.pend_period_vld = 1'b0;
    end

    // APB: one wait state, then the access completes.
    s_d.ready = bus_start;
    if (bus_start) begin
      s_d.slverr = 1'b0;
      case (apb_req.paddr)
        DPS_OFF_CTRL:    s_d.rdata = {25'h0000000, s_q.ctrl};
        DPS_OFF_DUTY_LO: s_d.rdata = {24'h000000, s_q.duty_val[7:0]};
        DPS_OFF_DUTY_HI: s_d.rdata = {24'h000000, s_q.duty_val[15:8]};
        DPS_OFF_PER_LO:  s_d.rdata = {24'h000000, s_q.period_val[7:0]};
        DPS_OFF_PER_HI:  s_d.rdata = {24'h000000, s_q.period_val[15:8]};
        DPS_OFF_STATUS:  s_d.rdata = {16'h0000, s_q.cnt};
        default: begin
          s_d.rdata = 32'h00000000;
          s_d.slverr = 1'b1;
        end
      endcase
      if (apb_req.pwrite) begin
        s_d.rdata = 32'h00000000;
      end
    end

    // A new commit is set after any clear above, so it is never lost.
    if (bus_done && apb_req.pwrite) begin
      case (apb_req.paddr)
        DPS_OFF_CTRL: begin
          s_d.ctrl = dps_ctrl_t'(apb_req.pwdata[6:0]);
          s_d.cnt = 16'h0000;
          s_d.pre = 6'h00;
          s_d.acc0 = 16'h0000;
          s_d.acc1 = 16'h0000;
        end
        DPS_OFF_DUTY_LO: begin
          if (dps_is_wide(s_q.ctrl.mode)) begin
            s_d.hold_duty = apb_req.pwdata[7:0];
          end else begin
            s_d.duty_val[7:0] = apb_req.pwdata[7:0];
          end
        end
        DPS_OFF_DUTY_HI: begin
          if (dps_is_wide(s_q.ctrl.mode)) begin
            s_d.pend_duty = {apb_req.pwdata[7:0], s_q.hold_duty};
            s_d.pend_duty_vld = 1'b1;
          end else begin
            s_d.duty_val[15:8] = apb_req.pwdata[7:0];
          end
        end
        DPS_OFF_PER_LO: begin
          if (dps_is_wide(s_q.ctrl.mode)) begin
            s_d.hold_period = apb_req.pwdata[7:0];
          end else begin
            s_d.period_val[7:0] = apb_req.pwdata[7:0];
          end
        end
        DPS_OFF_PER_HI: begin
          if (dps_is_wide(s_q.ctrl.mode)) begin
            s_d.pend_period = {apb_req.pwdata[7:0], s_q.hold_period};
            s_d.pend_period_vld = 1'b1;
          end else begin
            s_d.period_val[15:8] = apb_req.pwdata[7:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= DPS_STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign apb_rsp = '{prdata: s_q.rdata, pready: s_q.ready, pslverr: s_q.slverr};
  assign first_pulse_out = s_q.out0;
  assign first_pulse_oe = s_q.oe0;
  assign second_pulse_out = s_q.out1;
  assign second_pulse_oe = s_q.oe1;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_ctrl_write;
    ctrl_wr;
  endsequence

  sequence s_twin16_restart;
    (s_q.ctrl.mode == DPS_MODE_TWIN16) && tick && (s_q.cnt == 16'h0000);
  endsequence

  chk_twin8_fall: assert property (
    (s_q.ctrl.mode == DPS_MODE_TWIN8) && tick && (lo == s_q.duty_val[7:0])
    |=> !s_q.out0)
    else $error("first output did not fall at duty low byte");

  chk_twin8_rise: assert property (
    (s_q.ctrl.mode == DPS_MODE_TWIN8) && tick && (lo == s_q.period_val[15:8]) &&
    (lo != s_q.duty_val[15:8]) |=> s_q.out1)
    else $error("second output did not rise at period high byte");

  chk_twin8_wrap: assert property (
    (s_q.ctrl.mode == DPS_MODE_TWIN8) && tick && (lo == s_q.period_val[7:0]) &&
    !ctrl_wr |=> s_q.cnt == 16'h0000)
    else $error("twin 8-bit counter missed its period");

  chk_twin16_low: assert property (
    (s_q.ctrl.mode == DPS_MODE_TWIN16) && tick && (s_q.cnt >= s_q.duty_val)
    |=> !s_q.out0)
    else $error("first output high at or above duty");

  chk_twin16_high2: assert property (
    (s_q.ctrl.mode == DPS_MODE_TWIN16) && tick && (s_q.cnt < s_q.period_val)
    |=> s_q.out1)
    else $error("second output low below its compare value");

  chk_twin16_sync: assert property (
    s_twin16_restart ##0 ((s_q.duty_val != 16'h0000) && (s_q.period_val != 16'h0000))
    |=> s_q.out0 && s_q.out1)
    else $error("outputs did not rise together after wrap");

  chk_count_step: assert property (
    tick && !ctrl_wr && ((s_q.ctrl.mode == DPS_MODE_TWIN16) ||
    (s_q.ctrl.mode == DPS_MODE_NRZ)) |=> s_q.cnt == $past(s_q.cnt) + 16'h0001)
    else $error("counter did not advance by one on a tick");

  chk_density_carry: assert property (
    (s_q.ctrl.mode == DPS_MODE_NRZ) && tick
    |=> (s_q.out0 == $past(sum0[16])) && (s_q.out1 == $past(sum1[16])))
    else $error("density output differs from accumulator carry");

  chk_rz_return: assert property (
    (s_q.ctrl.mode == DPS_MODE_RZ) && (s_q.ctrl.clock_source_sel == DPS_SRC_SYSCLK) &&
    (s_q.ctrl.prescale_sel != 2'h0) && s_q.out1 && !ctrl_wr |-> ##[1:33] !s_q.out1)
    else $error("return-to-zero high did not return low");

  chk_dual8_duty: assert property (
    (s_q.ctrl.mode == DPS_MODE_DUAL8) && tick
    |=> (s_q.out0 == $past(below0_8)) && (s_q.out1 == $past(below1_8)))
    else $error("dual 8-bit output disagrees with its compare");

  chk_ctrl_clear: assert property (
    s_ctrl_write |=> (s_q.cnt == 16'h0000) && (s_q.pre == 6'h00))
    else $error("control write did not reset the counter");

  chk_hold_release: assert property (
    (s_q.ctrl.mode == DPS_MODE_HOLD) |=> !s_q.oe0 && !s_q.oe1 && (s_q.cnt == 16'h0000))
    else $error("pins not released in mode 7");

  chk_bus_answer: assert property (
    bus_start |=> s_q.ready ##1 !s_q.ready)
    else $error("APB answer not given after one wait state");

endmodule

/* dv/dps_pin_load.sv */
// Pin load on the two pulse outputs: a pull-down per pin and a high-time counter.
// Assumes outputs are sampled on the rising edge of the same clock as the block.
module dps_pin_load (
  // Clock and window control.
  input  wire logic        clk,
  input  wire logic        clr,
  // Pins as the block drives them.
  input  wire logic        out0,
  input  wire logic        oe0,
  input  wire logic        out1,
  input  wire logic        oe1,
  // Clocks seen high since the last clear.
  output logic [31:0]      hi0,
  output logic [31:0]      hi1
);
  timeunit 1ns;
  timeprecision 1ps;

  // A released pin falls to the board pull-down, never keeps its last value.
  logic pin0;
  logic pin1;
  assign pin0 = oe0 ? out0 : 1'b0;
  assign pin1 = oe1 ? out1 : 1'b0;

  always_ff @(posedge clk) begin
    if (clr) begin
      hi0 <= 32'h0;
      hi1 <= 32'h0;
    end else begin
      hi0 <= hi0 + {31'h0, pin0};
      hi1 <= hi1 + {31'h0, pin1};
    end
  end
endmodule

/* dv/dps_pulse_gen_tb.sv */
// Self-checking bench: APB register access plus high-time windows per mode.
// Assumes the design answers APB within a few cycles and that a released pin reads low.
module dps_pulse_gen_tb;
  import dps_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic         clk;
  logic         rst_b;
  dps_apb_req_t apb_req;
  dps_apb_rsp_t apb_rsp;
  logic [2:0]   src_pins;
  logic [2:0]   src_div;
  logic         o0, e0, o1, e1, clr;
  logic [31:0]  hi0, hi1, rd;
  logic         err;
  int           miscompares;
  int           compares;

  dps_pulse_gen DUT (.clk(clk), .rst_b(rst_b), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .clock_src_pins(src_pins), .first_pulse_out(o0), .first_pulse_oe(e0),
    .second_pulse_out(o1), .second_pulse_oe(e1));

  dps_pin_load load (.clk(clk), .clr(clr), .out0(o0), .oe0(e0), .out1(o1), .oe1(e1),
    .hi0(hi0), .hi1(hi1));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // The source pins toggle every eight clocks, so a rising edge comes every sixteen.
  always @(posedge clk) begin
    src_div <= src_div + 3'h1;
    if (src_div == 3'h3) src_pins <= ~src_pins;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One APB transfer; entered just after a rising edge, leaves one idle cycle behind.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    apb_req.psel    <= 1'b1;
    apb_req.pwrite  <= w;
    apb_req.paddr   <= a;
    apb_req.pwdata  <= d;
    apb_req.penable <= 1'b0;
    @(posedge clk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) miscompares++;
    rd  = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [31:0] cw(input logic [2:0] m, input logic [1:0] p,
                                     input logic [1:0] s);
    cw = {25'h0, m, p, s};
  endfunction

  // Loads duty and period with the generator stopped, low byte first.
  task automatic setv(input logic [15:0] duty, input logic [15:0] per);
    xfer(1'b1, DPS_OFF_CTRL, 32'h0);
    xfer(1'b1, DPS_OFF_DUTY_LO, {24'h0, duty[7:0]});
    xfer(1'b1, DPS_OFF_DUTY_HI, {24'h0, duty[15:8]});
    xfer(1'b1, DPS_OFF_PER_LO, {24'h0, per[7:0]});
    xfer(1'b1, DPS_OFF_PER_HI, {24'h0, per[15:8]});
  endtask

  // Stops the generator so no level is left over from the last mode, starts a
  // mode, lets it settle, then counts high clocks over whole periods. The counts
  // are read before the last edge updates them, so they cover exactly n clocks.
  task automatic run(input logic [31:0] c, input int n);
    xfer(1'b1, DPS_OFF_CTRL, 32'h0);
    xfer(1'b1, DPS_OFF_CTRL, c);
    repeat (130) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (n + 1) @(posedge clk);
  endtask

  initial begin
    rst_b    = 1'b0;
    apb_req  = '0;
    src_pins = 3'h0;
    src_div  = 3'h0;
    clr      = 1'b0;
    miscompares = 0;
    compares    = 0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    for (int a = 0; a < 6; a++) begin
      xfer(1'b0, 8'(a * 4), 32'h0);
      check(rd, 32'h0);
    end
    xfer(1'b0, 8'h18, 32'h0);
    check({31'h0, err}, 32'h1);
    // Holding stage: in a wide mode a lone low byte stays hidden, and a committed
    // pair waits for the counter cycle to end; stopping the generator ends it.
    xfer(1'b1, DPS_OFF_CTRL, cw(DPS_MODE_TWIN16, 2'h3, 2'h0));
    xfer(1'b1, DPS_OFF_DUTY_LO, 32'h34);
    xfer(1'b0, DPS_OFF_DUTY_LO, 32'h0);
    check(rd, 32'h0);
    xfer(1'b1, DPS_OFF_DUTY_HI, 32'h12);
    xfer(1'b0, DPS_OFF_DUTY_LO, 32'h0);
    check(rd, 32'h0);
    xfer(1'b1, DPS_OFF_CTRL, 32'h0);
    xfer(1'b0, DPS_OFF_DUTY_LO, 32'h0);
    check(rd, 32'h34);
    xfer(1'b0, DPS_OFF_DUTY_HI, 32'h0);
    check(rd, 32'h12);
    // Single 16-bit: only the first pin is driven.
    setv(16'h0003, 16'h0008);
    run(cw(DPS_MODE_SINGLE16, 2'h0, DPS_SRC_SYSCLK), 80);
    check(hi0, 32'd30);
    check({31'h0, e1}, 32'h0);
    // Twin 8-bit across every prescaler ratio.
    setv(16'h0603, 16'h0209);
    for (int p = 0; p < 4; p++) begin
      run(cw(DPS_MODE_TWIN8, 2'(p), DPS_SRC_SYSCLK), 100 << (2 * p));
      check(hi0, 32'(30 << (2 * p)));
      check(hi1, 32'(40 << (2 * p)));
    end
    run(cw(DPS_MODE_TWIN8, 2'h0, 2'h0), 800);
    check(hi0, 32'd240);
    check(hi1, 32'd320);
    setv(16'h0603, 16'h0009);
    run(cw(DPS_MODE_TWIN8, 2'h0, DPS_SRC_SYSCLK), 100);
    check(hi1, 32'd60);
    check({30'h0, e0, e1}, 32'h3);
    // Dual 8-bit: separate periods of five and ten clocks.
    setv(16'h0702, 16'h0904);
    run(cw(DPS_MODE_DUAL8, 2'h0, DPS_SRC_SYSCLK), 100);
    check(hi0, 32'd40);
    check(hi1, 32'd70);
    // Twin 16-bit over one full counter wrap.
    setv(16'h0100, 16'h0200);
    run(cw(DPS_MODE_TWIN16, 2'h0, DPS_SRC_SYSCLK), 65536);
    check(hi0, 32'd256);
    check(hi1, 32'd512);
    // Density modes with the lowest bit set, as for a reduced resolution; over
    // this short window the carry still repeats every four ticks.
    setv(16'h4001, 16'hc001);
    run(cw(DPS_MODE_NRZ, 2'h0, DPS_SRC_SYSCLK), 1024);
    check(hi0, 32'd256);
    check(hi1, 32'd768);
    run(cw(DPS_MODE_RZ, 2'h1, DPS_SRC_SYSCLK), 4096);
    check(hi0, 32'd512);
    check(hi1, 32'd1536);
    // Mode 7 stops the counter and releases both pins.
    run(cw(DPS_MODE_HOLD, 2'h0, DPS_SRC_SYSCLK), 50);
    check({30'h0, e0, e1}, 32'h0);
    check(hi0 + hi1, 32'h0);
    xfer(1'b0, DPS_OFF_STATUS, 32'h0);
    check(rd, 32'h0);
    wrap_up();
  end

  // The tests take about 82,000 clocks; the limit leaves some margin.
  initial begin
    repeat (95000) @(posedge clk);
    miscompares++;
    wrap_up();
  end
endmodule
